// >>> core/cmc_pkg.sv
package cmc_pkg;

    // ******************************************************
    // Register map (byte addresses)
    // ******************************************************
    localparam logic [7:0] CMC_STAT_ADDR = 8'h36 * 8'h04;
    localparam logic [7:0] CMC_MASK_ADDR = 8'h37 * 8'h04;
    localparam logic [7:0] CMC_CTRL_ADDR = 8'h40;
    localparam logic [7:0] CMC_INPUT_CURRENT_LIMIT_CODE_ADDR = 8'h44;

    // ******************************************************
    // Field positions
    // ******************************************************
    localparam int CMC_STAT_SUPPLY_BIT = 3;
    localparam int CMC_STAT_INPUT_CURRENT_LIMIT_CODE_BIT = 4;
    localparam int CMC_STAT_DONE_BIT = 5;
    localparam int CMC_STAT_CODE_LSB = 8;
    localparam int CMC_MASK_SUPPLY_BIT = 3;
    localparam int CMC_CTRL_CHG_BIT = 0;
    localparam int CMC_CTRL_TRK_BIT = 1;

    // ******************************************************
    // Reset values and limit code maximum
    // ******************************************************
    localparam logic [3:0] CMC_INPUT_CURRENT_LIMIT_CODE_DEFAULT = 4'h0;
    localparam logic [3:0] CMC_INPUT_CURRENT_LIMIT_CODE_MAX = 4'hf;
    localparam logic [1:0] CMC_CTRL_RESET = 2'h3;

    // ******************************************************
    // Charge status codes
    // ******************************************************
    localparam logic [3:0] CMC_CODE_OFF = 4'h0;
    localparam logic [3:0] CMC_CODE_TRICKLE = 4'h1;
    localparam logic [3:0] CMC_CODE_WEAK = 4'h2;
    localparam logic [3:0] CMC_CODE_CC = 4'h3;
    localparam logic [3:0] CMC_CODE_CV = 4'h4;
    localparam logic [3:0] CMC_CODE_DONE = 4'h5;
    localparam logic [3:0] CMC_CODE_FAULT = 4'h6;
    localparam logic [3:0] CMC_CODE_SUPPLY = 4'h7;

    // ******************************************************
    // Regulator target and isolation switch modes
    // ******************************************************
    localparam logic [1:0] CMC_ISO_OFF = 2'h0;
    localparam logic [1:0] CMC_ISO_ON = 2'h1;
    localparam logic [1:0] CMC_ISO_REG = 2'h2;
    localparam logic CMC_TGT_TRICKLE = 1'b0;
    localparam logic CMC_TGT_FAST = 1'b1;

    // ******************************************************
    // Timing
    // ******************************************************
    localparam longint CMC_CLK_HZ = 40000000;
    localparam longint CMC_TRK_MIN = 60;
    localparam longint CMC_TRK_CYCLES = CMC_TRK_MIN * 60 * CMC_CLK_HZ;
    localparam int CMC_END_US = 100;
    localparam longint CMC_END_CYCLES = CMC_END_US * CMC_CLK_HZ / 1000000;

    typedef enum logic [2:0] {
        CMC_ST_IDLE, CMC_ST_TRICKLE, CMC_ST_WEAK, CMC_ST_CC, CMC_ST_CV,
        CMC_ST_DONE, CMC_ST_FAULT, CMC_ST_SUPPLY
    } cmc_state_t;

endpackage

// >>> core/cmc_charger_ctrl.sv
// Our own choices: register access over APB and the address map.
`timescale 1ns/10ps
// Operation
// - Four-bit software input current limit code, 100 mA to 1500 mA.
// - Limit code defaults to 100 mA code after every supply power cycle.
// - Set input-limited flag when limit starves fast charge current in CC or weak mode.
// - Bad supply: regulator off, isolation switch on, until it clears.
// - Status 0x36 bit 3 shows supply between valid-low and overvoltage.
// - Mask bit in 0x37 gates supply-in-range onto power good.
// - Power-good mask reset value comes from a fuse input.
// - Battery below dead threshold charges in trickle with trickle current.
// - Trickle: isolation switch off, regulator at trickle level.
// - Trickle entered only when trickle enable bit is set.
// - Trickle over 60 minutes: stop, switch on, regulator off, fault code.
// - Between dead and weak: weak mode, switch on, fast-charge level.
// - Weak mode keeps trickle current source on too.
// - Above both thresholds: constant-current fast charge.
// - In CC, system node low makes isolation switch regulate.
// - Sense at termination voltage enters constant-voltage mode.
// - Four-bit status code follows trickle, CC and CV modes.
// - After done, battery below termination minus hysteresis restarts charge.
// - When not charging, regulator holds trickle-level target.
// - CV current below end level for end time: switch off, done flag.
// - Charge enable cleared: switch off, regulator on at trickle level; in fault the code keeps switch on, regulator off.
module cmc_charger_ctrl
    import cmc_pkg::*;
#(
    parameter longint TRK_CYCLES = CMC_TRK_CYCLES,
    parameter longint END_CYCLES = CMC_END_CYCLES
) (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic fuse_power_good_out_mask,
    input wire logic supply_in_range,
    input wire logic input_supply_overvoltage,
    input wire logic batt_above_dead,
    input wire logic batt_above_weak,
    input wire logic battery_sense_at_term,
    input wire logic battery_sense_below_recharge,
    input wire logic system_node_below_fast,
    input wire logic current_below_end,
    input wire logic input_limit_active,
    output logic [1:0] battery_isolation_switch,
    output logic regulator_enable,
    output logic regulator_target,
    output logic trickle_current_enable,
    output logic fast_current_enable,
    output logic [3:0] input_current_limit_code,
    output logic power_good_out_o,
    output logic power_good_out_oe_n
);

    // ******************************************************
    // State
    // ******************************************************
    cmc_state_t state_r, state_nxt;
    logic [3:0] input_current_limit_code_r, input_current_limit_code_nxt;
    logic [1:0] ctrl_r, ctrl_nxt;
    logic mask_r, mask_nxt;
    logic fuse_done_r, fuse_done_nxt;
    logic input_current_limit_code_flag_r, input_current_limit_code_flag_nxt;
    logic done_flag_r, done_flag_nxt;
    logic [37:0] trk_cnt_r, trk_cnt_nxt;
    logic [31:0] end_cnt_r, end_cnt_nxt;
    logic [1:0] iso_r, iso_nxt;
    logic reg_en_r, reg_en_nxt;
    logic tgt_r, tgt_nxt;
    logic trk_i_r, trk_i_nxt;
    logic fast_i_r, fast_i_nxt;
    logic pg_r, pg_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;

    logic acc, wr, mapped;
    logic supply_ok;

    function automatic logic [3:0] cmc_code(input cmc_state_t s);
        case (s)
            CMC_ST_TRICKLE: cmc_code = CMC_CODE_TRICKLE;
            CMC_ST_WEAK: cmc_code = CMC_CODE_WEAK;
            CMC_ST_CC: cmc_code = CMC_CODE_CC;
            CMC_ST_CV: cmc_code = CMC_CODE_CV;
            CMC_ST_DONE: cmc_code = CMC_CODE_DONE;
            CMC_ST_FAULT: cmc_code = CMC_CODE_FAULT;
            CMC_ST_SUPPLY: cmc_code = CMC_CODE_SUPPLY;
            default: cmc_code = CMC_CODE_OFF;
        endcase
    endfunction

    function automatic logic cmc_hit(input logic [7:0] a);
        cmc_hit = (a == CMC_STAT_ADDR) || (a == CMC_MASK_ADDR) ||
            (a == CMC_CTRL_ADDR) || (a == CMC_INPUT_CURRENT_LIMIT_CODE_ADDR);
    endfunction

    // ******************************************************
    // APB slave, one wait state per access (pready registered)
    // ******************************************************
    always_comb begin
        acc = psel && penable && !pready_r;
        wr = acc && pwrite;
        mapped = cmc_hit(paddr);
        pready_nxt = acc;
        pslverr_nxt = acc && !mapped;
        prdata_nxt = '0;
        if (acc && !pwrite) begin
            case (paddr)
                CMC_STAT_ADDR: begin
                    prdata_nxt[CMC_STAT_SUPPLY_BIT] = supply_ok;
                    prdata_nxt[CMC_STAT_INPUT_CURRENT_LIMIT_CODE_BIT] = input_current_limit_code_flag_r;
                    prdata_nxt[CMC_STAT_DONE_BIT] = done_flag_r;
                    prdata_nxt[CMC_STAT_CODE_LSB +: 4] = cmc_code(state_r);
                end
                CMC_MASK_ADDR: prdata_nxt[CMC_MASK_SUPPLY_BIT] = mask_r;
                CMC_CTRL_ADDR: prdata_nxt[1:0] = ctrl_r;
                CMC_INPUT_CURRENT_LIMIT_CODE_ADDR: prdata_nxt[3:0] = input_current_limit_code_r;
                default: prdata_nxt = '0;
            endcase
        end
    end

    // ******************************************************
    // Software registers
    // ******************************************************
    always_comb begin
        input_current_limit_code_nxt = input_current_limit_code_r;
        ctrl_nxt = ctrl_r;
        mask_nxt = mask_r;
        fuse_done_nxt = 1'b1;
        if (!fuse_done_r) begin
            mask_nxt = fuse_power_good_out_mask;
        end else if (wr && paddr == CMC_MASK_ADDR) begin
            mask_nxt = pwdata[CMC_MASK_SUPPLY_BIT];
        end
        if (wr && paddr == CMC_CTRL_ADDR) begin
            ctrl_nxt = pwdata[1:0];
        end
        if (wr && paddr == CMC_INPUT_CURRENT_LIMIT_CODE_ADDR) begin
            input_current_limit_code_nxt = pwdata[3:0];
        end
        supply_ok = supply_in_range && !input_supply_overvoltage;
        pg_nxt = !(mask_r && !supply_ok);
    end

    // ******************************************************
    // Mode machine
    // ******************************************************
    always_comb begin
        state_nxt = state_r;
        trk_cnt_nxt = '0;
        end_cnt_nxt = '0;
        done_flag_nxt = done_flag_r;
        input_current_limit_code_flag_nxt = input_current_limit_code_flag_r;
        if (wr && paddr == CMC_STAT_ADDR && pwdata[CMC_STAT_INPUT_CURRENT_LIMIT_CODE_BIT]) begin
            input_current_limit_code_flag_nxt = 1'b0;
        end
        if (wr && paddr == CMC_STAT_ADDR && pwdata[CMC_STAT_DONE_BIT]) begin
            done_flag_nxt = 1'b0;
        end
        if ((state_r == CMC_ST_CC || state_r == CMC_ST_WEAK) && input_limit_active) begin
            input_current_limit_code_flag_nxt = 1'b1;
        end
        if (!supply_ok) begin
            state_nxt = CMC_ST_SUPPLY;
        end else begin
            case (state_r)
                CMC_ST_SUPPLY, CMC_ST_IDLE: begin
                    if (ctrl_r[CMC_CTRL_CHG_BIT]) begin
                        if (!batt_above_dead) begin
                            state_nxt = ctrl_r[CMC_CTRL_TRK_BIT] ? CMC_ST_TRICKLE
                                : CMC_ST_IDLE;
                        end else if (!batt_above_weak) begin
                            state_nxt = CMC_ST_WEAK;
                        end else if (battery_sense_at_term) begin
                            state_nxt = CMC_ST_CV;
                        end else begin
                            state_nxt = CMC_ST_CC;
                        end
                    end else begin
                        state_nxt = CMC_ST_IDLE;
                    end
                end
                CMC_ST_TRICKLE: begin
                    trk_cnt_nxt = trk_cnt_r + 38'h1;
                    if (!ctrl_r[CMC_CTRL_CHG_BIT] || !ctrl_r[CMC_CTRL_TRK_BIT]) begin
                        state_nxt = CMC_ST_IDLE;
                    end else if (batt_above_dead) begin
                        state_nxt = CMC_ST_WEAK;
                    end else if (trk_cnt_r >= 38'(TRK_CYCLES)) begin
                        state_nxt = CMC_ST_FAULT;
                    end
                end
                CMC_ST_WEAK: begin
                    if (!ctrl_r[CMC_CTRL_CHG_BIT]) begin
                        state_nxt = CMC_ST_IDLE;
                    end else if (!batt_above_dead) begin
                        state_nxt = CMC_ST_IDLE;
                    end else if (batt_above_weak) begin
                        state_nxt = CMC_ST_CC;
                    end
                end
                CMC_ST_CC: begin
                    if (!ctrl_r[CMC_CTRL_CHG_BIT]) begin
                        state_nxt = CMC_ST_IDLE;
                    end else if (!batt_above_dead) begin
                        state_nxt = CMC_ST_IDLE;
                    end else if (battery_sense_at_term) begin
                        state_nxt = CMC_ST_CV;
                    end
                end
                CMC_ST_CV: begin
                    if (current_below_end) begin
                        end_cnt_nxt = end_cnt_r + 32'h1;
                    end
                    if (!ctrl_r[CMC_CTRL_CHG_BIT]) begin
                        state_nxt = CMC_ST_IDLE;
                    end else if (current_below_end && end_cnt_r >= 32'(END_CYCLES) - 32'h1) begin
                        state_nxt = CMC_ST_DONE;
                        done_flag_nxt = 1'b1;
                    end
                end
                CMC_ST_DONE: begin
                    if (!ctrl_r[CMC_CTRL_CHG_BIT]) begin
                        state_nxt = CMC_ST_IDLE;
                    end else if (battery_sense_below_recharge) begin
                        state_nxt = CMC_ST_IDLE;
                    end
                end
                CMC_ST_FAULT: state_nxt = CMC_ST_FAULT;
                default: state_nxt = CMC_ST_IDLE;
            endcase
        end
    end

    // ******************************************************
    // Power stage commands
    // ******************************************************
    always_comb begin
        iso_nxt = CMC_ISO_OFF;
        reg_en_nxt = 1'b1;
        tgt_nxt = CMC_TGT_TRICKLE;
        trk_i_nxt = 1'b0;
        fast_i_nxt = 1'b0;
        case (state_nxt)
            CMC_ST_SUPPLY, CMC_ST_FAULT: begin
                iso_nxt = CMC_ISO_ON;
                reg_en_nxt = 1'b0;
            end
            CMC_ST_TRICKLE: begin
                trk_i_nxt = 1'b1;
            end
            CMC_ST_WEAK: begin
                iso_nxt = CMC_ISO_ON;
                tgt_nxt = CMC_TGT_FAST;
                trk_i_nxt = 1'b1;
                fast_i_nxt = 1'b1;
            end
            CMC_ST_CC, CMC_ST_CV: begin
                iso_nxt = system_node_below_fast ? CMC_ISO_REG : CMC_ISO_ON;
                tgt_nxt = CMC_TGT_FAST;
                fast_i_nxt = 1'b1;
            end
            default: iso_nxt = CMC_ISO_OFF;
        endcase
    end

    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= CMC_ST_IDLE;
            input_current_limit_code_r <= CMC_INPUT_CURRENT_LIMIT_CODE_DEFAULT;
            ctrl_r <= CMC_CTRL_RESET;
            mask_r <= 1'b0;
            fuse_done_r <= 1'b0;
            input_current_limit_code_flag_r <= 1'b0;
            done_flag_r <= 1'b0;
            trk_cnt_r <= '0;
            end_cnt_r <= '0;
            iso_r <= CMC_ISO_OFF;
            reg_en_r <= 1'b0;
            tgt_r <= CMC_TGT_TRICKLE;
            trk_i_r <= 1'b0;
            fast_i_r <= 1'b0;
            pg_r <= 1'b1;
            prdata_r <= '0;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else begin
            state_r <= state_nxt;
            input_current_limit_code_r <= input_current_limit_code_nxt;
            ctrl_r <= ctrl_nxt;
            mask_r <= mask_nxt;
            fuse_done_r <= fuse_done_nxt;
            input_current_limit_code_flag_r <= input_current_limit_code_flag_nxt;
            done_flag_r <= done_flag_nxt;
            trk_cnt_r <= trk_cnt_nxt;
            end_cnt_r <= end_cnt_nxt;
            iso_r <= iso_nxt;
            reg_en_r <= reg_en_nxt;
            tgt_r <= tgt_nxt;
            trk_i_r <= trk_i_nxt;
            fast_i_r <= fast_i_nxt;
            pg_r <= pg_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign battery_isolation_switch = iso_r;
    assign regulator_enable = reg_en_r;
    assign regulator_target = tgt_r;
    assign trickle_current_enable = trk_i_r;
    assign fast_current_enable = fast_i_r;
    assign input_current_limit_code = input_current_limit_code_r;
    assign power_good_out_o = 1'b0;
    assign power_good_out_oe_n = pg_r;

    // ******************************************************
    // Checks
    // ******************************************************
    supply_bad_a: assert property (@(posedge clk) disable iff (!reset_n)
        !supply_ok |=> (iso_r == CMC_ISO_ON) && !reg_en_r)
        else $error("bad supply not isolated");
    trickle_iso_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_r == CMC_ST_TRICKLE |-> iso_r == CMC_ISO_OFF && tgt_r == CMC_TGT_TRICKLE)
        else $error("trickle drive wrong");
    trickle_en_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(state_r == CMC_ST_TRICKLE) |-> $past(ctrl_r[CMC_CTRL_TRK_BIT]))
        else $error("trickle without enable");
    weak_iso_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_r == CMC_ST_WEAK |-> trk_i_r && fast_i_r && iso_r == CMC_ISO_ON)
        else $error("weak drive wrong");
    cv_entry_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_r == CMC_ST_CC && supply_ok && ctrl_r[CMC_CTRL_CHG_BIT]
        && battery_sense_at_term |=> state_r == CMC_ST_CV)
        else $error("cv not entered");
    done_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(state_r == CMC_ST_DONE) |-> done_flag_r && iso_r == CMC_ISO_OFF)
        else $error("done without flag");
    status_code_a: assert property (@(posedge clk) disable iff (!reset_n)
        acc && !pwrite && paddr == CMC_STAT_ADDR
        |=> prdata_r[CMC_STAT_CODE_LSB +: 4] == cmc_code($past(state_r)))
        else $error("status code mismatch");
    disable_a: assert property (@(posedge clk) disable iff (!reset_n)
        supply_ok && !ctrl_r[CMC_CTRL_CHG_BIT] && state_r != CMC_ST_FAULT
        |=> iso_r == CMC_ISO_OFF && reg_en_r)
        else $error("disable drive wrong");
    power_good_out_a: assert property (@(posedge clk) disable iff (!reset_n)
        ##1 pg_r == !($past(mask_r) && !$past(supply_ok)))
        else $error("power good mismatch");
    input_current_limit_code_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state_r == CMC_ST_CC || state_r == CMC_ST_WEAK) && input_limit_active |=> input_current_limit_code_flag_r)
        else $error("input limit flag not set");
    fault_stop_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_r == CMC_ST_FAULT |-> iso_r == CMC_ISO_ON && !reg_en_r && !trk_i_r && !fast_i_r)
        else $error("fault drive wrong");
    trickle_time_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_r == CMC_ST_TRICKLE && supply_ok && ctrl_r[CMC_CTRL_CHG_BIT]
        && ctrl_r[CMC_CTRL_TRK_BIT] && !batt_above_dead && trk_cnt_r >= 38'(TRK_CYCLES)
        |=> state_r == CMC_ST_FAULT)
        else $error("trickle timeout missed");
    cc_regulate_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_r == CMC_ST_CC && supply_ok && ctrl_r[CMC_CTRL_CHG_BIT] && batt_above_dead
        && !battery_sense_at_term && system_node_below_fast |=> iso_r == CMC_ISO_REG)
        else $error("isolation switch not regulating");
    recharge_start_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_r == CMC_ST_DONE && supply_ok && ctrl_r[CMC_CTRL_CHG_BIT]
        && battery_sense_below_recharge |=> state_r == CMC_ST_IDLE)
        else $error("recharge not started");
    dead_trickle_a: assert property (@(posedge clk) disable iff (!reset_n)
        state_r == CMC_ST_IDLE && supply_ok && ctrl_r[CMC_CTRL_CHG_BIT]
        && ctrl_r[CMC_CTRL_TRK_BIT] && !batt_above_dead |=> state_r == CMC_ST_TRICKLE)
        else $error("trickle not entered");

endmodule

// >>> test/cmc_analog_model.sv
`timescale 1ns/10ps
module cmc_analog_model
    import cmc_pkg::*;
(
    input wire logic clk,
    input wire logic [2:0] batt_level,
    output logic batt_above_dead,
    output logic batt_above_weak,
    output logic battery_sense_at_term,
    output logic battery_sense_below_recharge
);
    // Levels: 0 dead, 1 weak, 2 charged below recharge, 3 at termination, 4 rested full
    // Comparators settle one clock after the cell level moves
    always_ff @(posedge clk) begin
        batt_above_dead <= batt_level >= 3'h1;
        batt_above_weak <= batt_level >= 3'h2;
        battery_sense_at_term <= batt_level == 3'h3;
        battery_sense_below_recharge <= batt_level <= 3'h2;
    end
endmodule

// >>> test/cmc_charger_ctrl_bench.sv
`timescale 1ns/10ps
module cmc_charger_ctrl_bench
    import cmc_pkg::*;
;
    logic clk, reset_n, psel, penable, pwrite, pready, pslverr, rd_err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd_data;
    logic fuse_power_good_out_mask, supply_in_range, input_supply_overvoltage;
    logic system_node_below_fast, current_below_end, input_limit_active;
    logic batt_above_dead, batt_above_weak, battery_sense_at_term, battery_sense_below_recharge;
    logic [2:0] batt_level;
    logic [1:0] iso;
    logic reg_en, reg_tgt, trk_en, fst_en, pg_oe_n, pg_o;
    logic [3:0] input_current_limit_code_code;
    int error_cnt, total_checks;

    cmc_charger_ctrl #(.TRK_CYCLES(200), .END_CYCLES(4)) i_dut (
        .clk, .reset_n, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
        .pslverr, .fuse_power_good_out_mask, .supply_in_range, .input_supply_overvoltage,
        .batt_above_dead, .batt_above_weak, .battery_sense_at_term,
        .battery_sense_below_recharge, .system_node_below_fast, .current_below_end,
        .input_limit_active, .battery_isolation_switch(iso), .regulator_enable(reg_en),
        .regulator_target(reg_tgt), .trickle_current_enable(trk_en),
        .fast_current_enable(fst_en), .input_current_limit_code(input_current_limit_code_code),
        .power_good_out_o(pg_o), .power_good_out_oe_n(pg_oe_n)
    );

    cmc_analog_model i_model (
        .clk, .batt_level, .batt_above_dead, .batt_above_weak, .battery_sense_at_term,
        .battery_sense_below_recharge
    );

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // ****************************************
    // Shared tasks
    // ****************************************
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("BAD t=%0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        rd_data = prdata;
        rd_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Polls the status code, then lets the power outputs follow the state
    task wait_code(input logic [3:0] c);
        for (int i = 0; i < 120; i++) begin
            apb(1'b0, CMC_STAT_ADDR, 32'h0);
            if (rd_data[11:8] === c) break;
        end
        chk(32'(rd_data[11:8]), 32'(c));
        repeat (2) @(posedge clk);
    endtask

    task finish_test();
        $display("checks %0d mismatches %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask

    // ****************************************
    // Scenarios
    // ****************************************
    task t_regs();
        apb(1'b0, CMC_INPUT_CURRENT_LIMIT_CODE_ADDR, 32'h0);
        chk(rd_data, 32'(CMC_INPUT_CURRENT_LIMIT_CODE_DEFAULT));
        apb(1'b0, CMC_CTRL_ADDR, 32'h0);
        chk(rd_data, 32'(CMC_CTRL_RESET));
        apb(1'b0, CMC_MASK_ADDR, 32'h0);
        chk(rd_data, 32'h1 << CMC_MASK_SUPPLY_BIT);
        apb(1'b0, 8'h10, 32'h0);
        chk(32'(rd_err), 32'h1);
        apb(1'b1, CMC_INPUT_CURRENT_LIMIT_CODE_ADDR, 32'(CMC_INPUT_CURRENT_LIMIT_CODE_MAX));
        apb(1'b0, CMC_INPUT_CURRENT_LIMIT_CODE_ADDR, 32'h0);
        chk(rd_data, 32'(CMC_INPUT_CURRENT_LIMIT_CODE_MAX));
        chk(32'(input_current_limit_code_code), 32'(CMC_INPUT_CURRENT_LIMIT_CODE_MAX));
        $display("test regs done");
    endtask

    task t_supply();
        wait_code(CMC_CODE_CC);
        chk(32'(rd_data[CMC_STAT_SUPPLY_BIT]), 32'h1);
        chk(32'(pg_oe_n), 32'h1);
        input_supply_overvoltage <= 1'b1;
        wait_code(CMC_CODE_SUPPLY);
        chk(32'(rd_data[CMC_STAT_SUPPLY_BIT]), 32'h0);
        chk(32'({iso, reg_en}), 32'({CMC_ISO_ON, 1'b0}));
        chk(32'(pg_oe_n), 32'h0);
        chk(32'(pg_o), 32'h0);
        apb(1'b1, CMC_MASK_ADDR, 32'h0);
        apb(1'b0, CMC_MASK_ADDR, 32'h0);
        chk(32'(pg_oe_n), 32'h1);
        input_supply_overvoltage <= 1'b0;
        wait_code(CMC_CODE_CC);
        $display("test supply done");
    endtask

    task t_charge();
        batt_level <= 3'h0;
        wait_code(CMC_CODE_TRICKLE);
        chk(32'({iso, reg_en, reg_tgt, trk_en}), 32'({CMC_ISO_OFF, 2'b10, 1'b1}));
        batt_level <= 3'h1;
        wait_code(CMC_CODE_WEAK);
        chk(32'({iso, reg_tgt, trk_en}), 32'({CMC_ISO_ON, CMC_TGT_FAST, 1'b1}));
        batt_level <= 3'h2;
        system_node_below_fast <= 1'b1;
        input_limit_active <= 1'b1;
        wait_code(CMC_CODE_CC);
        apb(1'b0, CMC_STAT_ADDR, 32'h0);
        chk(32'(rd_data[CMC_STAT_INPUT_CURRENT_LIMIT_CODE_BIT]), 32'h1);
        chk(32'({iso, fst_en}), 32'({CMC_ISO_REG, 1'b1}));
        system_node_below_fast <= 1'b0;
        input_limit_active <= 1'b0;
        batt_level <= 3'h3;
        wait_code(CMC_CODE_CV);
        current_below_end <= 1'b1;
        repeat (3) @(posedge clk);
        current_below_end <= 1'b0;
        repeat (8) @(posedge clk);
        wait_code(CMC_CODE_CV);
        current_below_end <= 1'b1;
        wait_code(CMC_CODE_DONE);
        chk(32'(rd_data[CMC_STAT_DONE_BIT]), 32'h1);
        chk(32'({iso, reg_en, reg_tgt}), 32'({CMC_ISO_OFF, 1'b1, CMC_TGT_TRICKLE}));
        current_below_end <= 1'b0;
        batt_level <= 3'h4;
        repeat (8) @(posedge clk);
        wait_code(CMC_CODE_DONE);
        batt_level <= 3'h2;
        wait_code(CMC_CODE_CC);
        $display("test charge done");
    endtask

    task t_disable();
        apb(1'b1, CMC_CTRL_ADDR, 32'h1 << CMC_CTRL_TRK_BIT);
        wait_code(CMC_CODE_OFF);
        chk(32'({iso, reg_en, reg_tgt}), 32'({CMC_ISO_OFF, 1'b1, CMC_TGT_TRICKLE}));
        apb(1'b1, CMC_CTRL_ADDR, 32'h1 << CMC_CTRL_CHG_BIT);
        batt_level <= 3'h0;
        repeat (10) @(posedge clk);
        apb(1'b0, CMC_STAT_ADDR, 32'h0);
        chk(32'(rd_data[11:8] === CMC_CODE_TRICKLE), 32'h0);
        apb(1'b1, CMC_CTRL_ADDR, 32'(CMC_CTRL_RESET));
        wait_code(CMC_CODE_TRICKLE);
        wait_code(CMC_CODE_FAULT);
        chk(32'({iso, reg_en}), 32'({CMC_ISO_ON, 1'b0}));
        $display("test disable done");
    endtask

    // Supply power cycle: limit returns to default, mask reloads from the fuse
    task t_cycle();
        fuse_power_good_out_mask <= 1'b0;
        reset_n <= 1'b0;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        apb(1'b0, CMC_INPUT_CURRENT_LIMIT_CODE_ADDR, 32'h0);
        chk(rd_data, 32'(CMC_INPUT_CURRENT_LIMIT_CODE_DEFAULT));
        chk(32'(input_current_limit_code_code), 32'(CMC_INPUT_CURRENT_LIMIT_CODE_DEFAULT));
        apb(1'b0, CMC_MASK_ADDR, 32'h0);
        chk(rd_data, 32'h0);
        $display("test cycle done");
    endtask

    initial begin
        error_cnt = 0;
        total_checks = 0;
        reset_n = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        fuse_power_good_out_mask = 1'b1;
        supply_in_range = 1'b1;
        input_supply_overvoltage = 1'b0;
        system_node_below_fast = 1'b0;
        current_below_end = 1'b0;
        input_limit_active = 1'b0;
        batt_level = 3'h2;
        repeat (10) @(posedge clk);
        reset_n <= 1'b1;
        t_regs();
        t_supply();
        t_charge();
        t_disable();
        t_cycle();
        finish_test();
    end

    initial begin
        repeat (20000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
endmodule
